//--- exec_state_pkg.sv
package exec_state_pkg;
	// ==========================================
	// field positions within the combined status word
	localparam int unsigned UPPER_HI = 26;
	localparam int unsigned UPPER_LO = 25;
	localparam int unsigned ISET_POS = 24;
	localparam int unsigned LOWER_HI = 15;
	localparam int unsigned LOWER_LO = 10;
	localparam int unsigned RESUME_HI = 15;
	localparam int unsigned RESUME_LO = 12;
	localparam int unsigned RSVD_A_HI = 23;
	localparam int unsigned RSVD_A_LO = 16;
	localparam int unsigned RSVD_B_HI = 9;
	localparam int unsigned RSVD_B_LO = 6;
	// ==========================================
	// reset values
	localparam logic [7:0] EXEC_FIELD_RESET = 8'h00;
	localparam logic ISET_RESET = 1'b1;
	localparam logic [3:0] RESUME_RESET = 4'h0;
	// at most four instructions in a conditional block
	localparam logic [2:0] BLOCK_MAX = 3'h4;
	// ==========================================
	// status-move view selects
	typedef enum logic [1:0] {
		VIEW_FULL,
		VIEW_EXEC,
		VIEW_APP_INT,
		VIEW_APP
	} view_t;
	// field content kind
	typedef enum logic [1:0] {
		MODE_IDLE,
		MODE_RESUME,
		MODE_BLOCK
	} mode_t;
endpackage

//--- exec_state_bits.sv
`timescale 1ns/100ps
// Overview of operation
// - split field holds resume or block state
// - resume state forces upper pair zero
// - resume state forces bits 11:10 zero
// - interrupted multi-transfer records next register
// - return resumes transfer from recorded register
// - block covers up to four following instructions
// - block conditions are same or inverse
// - read-only set-state bit resets to one
// - only listed events change set-state bit
// - after first vector fetch, execution with bit clear raises fault
// - reserved bits read zero, software preserves them
// - split field read-only, resets to zero
// - field meaningful only in full/exec views
// - application reads give zero, writes ignored
// - reset copies vector bit 0 into set-state
module exec_state_bits (
	input wire logic sys_clk, // core clock
	input wire logic rstn, // asynchronous reset, active low
	input wire logic exec_valid, // an instruction is issued this cycle
	input wire logic exec_done, // issued instruction retires
	input wire logic block_start, // conditional-block prefix retires
	input wire logic [3:0] block_cond, // base condition of the block
	input wire logic [3:0] block_mask, // prefix mask, trailing one ends block
	input wire logic multi_suspend, // multi-transfer interrupted
	input wire logic [3:0] multi_next_reg, // next register operand number
	input wire logic multi_finish, // multi-transfer completed
	input wire logic exc_entry, // exception entry
	input wire logic exc_return, // exception return
	input wire logic [31:0] stacked_status, // status word popped on return
	input wire logic vector_load, // vector fetched (entry or reset)
	input wire logic [31:0] vector_word, // fetched vector value
	input wire logic branch_exch, // branch-exchange or pop into pc
	input wire logic [31:0] branch_target, // target address of that branch
	input wire logic status_read, // status-move read request
	input wire logic status_write, // status-move write request
	input wire logic privileged, // access is privileged
	input wire logic [1:0] status_view, // selected view
	input wire logic [31:0] status_wdata, // write data, ignored for this view
	output logic [31:0] status_rdata, // read data, execution-state bits
	output logic [31:0] stack_status, // execution bits saved on entry
	output logic resume_valid, // a suspended transfer should resume
	output logic [3:0] resume_reg, // register to resume from
	output logic [3:0] block_cond_out, // condition for current instruction
	output logic block_active, // current instruction is conditional
	output logic iset_fault // fault or lockup request
);
	// ==========================================
	// state registers
	logic [7:0] field_q, field_d; // {26:25, 15:10}
	logic iset_q, iset_d;
	logic boot_q, boot_d; // waiting for reset vector
	logic [31:0] stack_q, stack_d;
	logic [31:0] rdata_q, rdata_d;
	logic fault_q, fault_d;
	exec_state_pkg::mode_t mode_q, mode_d;
	logic [31:0] exec_word;

	// build the execution bits in word position; reserved bits stay zero
	always_comb begin
		exec_word = 32'h0000_0000;
		exec_word[exec_state_pkg::UPPER_HI:exec_state_pkg::UPPER_LO] = field_q[7:6];
		exec_word[exec_state_pkg::ISET_POS] = iset_q;
		exec_word[exec_state_pkg::LOWER_HI:exec_state_pkg::LOWER_LO] = field_q[5:0];
	end

	// next-state for field, set-state bit and stacking
	always_comb begin
		field_d = field_q;
		iset_d = iset_q;
		// faults stay held off until the first vector has been fetched
		boot_d = boot_q & ~vector_load;
		stack_d = stack_q;
		mode_d = mode_q;
		fault_d = 1'b0;
		rdata_d = 32'h0000_0000;
		// set-state bit changes only on the listed events
		if (vector_load) begin
			iset_d = vector_word[0];
		end else if (exc_return) begin
			iset_d = stacked_status[exec_state_pkg::ISET_POS];
		end else if (branch_exch) begin
			iset_d = branch_target[0];
		end
		// execution with the bit clear is refused
		if (exec_valid && !iset_q && !boot_q) begin
			fault_d = 1'b1;
		end
		if (exc_entry) begin
			stack_d = exec_word;
			field_d = exec_state_pkg::EXEC_FIELD_RESET;
			mode_d = exec_state_pkg::MODE_IDLE;
		end else if (exc_return) begin
			// restore saved field
			field_d = {stacked_status[exec_state_pkg::UPPER_HI:exec_state_pkg::UPPER_LO],
				stacked_status[exec_state_pkg::LOWER_HI:exec_state_pkg::LOWER_LO]};
			if (field_d == 8'h00) begin
				mode_d = exec_state_pkg::MODE_IDLE;
			end else if (field_d[7:6] == 2'h0 && field_d[1:0] == 2'h0) begin
				mode_d = exec_state_pkg::MODE_RESUME;
			end else begin
				mode_d = exec_state_pkg::MODE_BLOCK;
			end
		end else if (multi_suspend) begin
			// record next operand; other field bits forced zero
			field_d = {2'h0, multi_next_reg, 2'h0};
			mode_d = exec_state_pkg::MODE_RESUME;
		end else if (multi_finish && mode_q == exec_state_pkg::MODE_RESUME) begin
			field_d = exec_state_pkg::EXEC_FIELD_RESET;
			mode_d = exec_state_pkg::MODE_IDLE;
		end else if (block_start && block_mask != 4'h0) begin
			// load base condition and mask
			field_d = {block_cond[1:0], block_cond[3:2], block_mask};
			mode_d = exec_state_pkg::MODE_BLOCK;
		end else if (exec_done && mode_q == exec_state_pkg::MODE_BLOCK) begin
			// advance: shift mask into condition lsb, block ends when mask empties
			if (field_q[2:0] == 3'h0) begin
				field_d = exec_state_pkg::EXEC_FIELD_RESET;
				mode_d = exec_state_pkg::MODE_IDLE;
			end else begin
				field_d = {field_q[7:6], field_q[5:4], field_q[3:0] << 1};
				field_d[6] = field_q[3];
			end
		end
		// only full or exec views by privileged code see the bits
		if (status_read && privileged &&
			(status_view == exec_state_pkg::VIEW_FULL || status_view == exec_state_pkg::VIEW_EXEC)) begin
			rdata_d = exec_word;
		end
		// writes never reach this field
	end

	// register the state
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			field_q <= exec_state_pkg::EXEC_FIELD_RESET;
			iset_q <= exec_state_pkg::ISET_RESET;
			boot_q <= 1'b1;
			stack_q <= 32'h0000_0000;
			rdata_q <= 32'h0000_0000;
			fault_q <= 1'b0;
			mode_q <= exec_state_pkg::MODE_IDLE;
		end else begin
			field_q <= field_d;
			iset_q <= iset_d;
			boot_q <= boot_d;
			stack_q <= stack_d;
			rdata_q <= rdata_d;
			fault_q <= fault_d;
			mode_q <= mode_d;
		end
	end

	// outputs
	assign status_rdata = rdata_q;
	assign stack_status = stack_q;
	assign iset_fault = fault_q;
	assign resume_valid = (mode_q == exec_state_pkg::MODE_RESUME);
	assign resume_reg = field_q[5:2];
	assign block_active = (mode_q == exec_state_pkg::MODE_BLOCK);
	assign block_cond_out = {field_q[5:4], field_q[7:6]}; // same or inverted lsb

	// ==========================================
	// assertions
	resume_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		multi_suspend && !exc_entry && !exc_return |=> field_q[7:6] == 2'h0 && field_q[1:0] == 2'h0)
		else $error("resume state has nonzero forced bits");
	resume_reg_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		multi_suspend && !exc_entry && !exc_return |=> resume_valid && resume_reg == $past(multi_next_reg))
		else $error("resume register not recorded");
	rsvd_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		status_rdata[23:16] == 8'h00 && status_rdata[9:6] == 4'h0)
		else $error("reserved bits not zero");
	app_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		status_read && !privileged |=> status_rdata == 32'h0000_0000)
		else $error("application read returned bits");
	iset_fault_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		exec_valid && !iset_q && !boot_q |=> iset_fault)
		else $error("no fault on clear set-state bit");
	iset_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		!vector_load && !exc_return && !branch_exch |=> $stable(iset_q))
		else $error("set-state bit changed without cause");
	vector_copy_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		vector_load |=> iset_q == $past(vector_word[0]))
		else $error("vector bit 0 not copied");
	sequence entry_s;
		exc_entry && !exc_return;
	endsequence
	stack_save_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		entry_s |=> stack_status == $past(exec_word) && field_q == 8'h00)
		else $error("exception entry did not save state");
	block_len_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		block_start && block_mask == 4'h8 && !exc_entry && !exc_return && !multi_suspend
		##1 exec_done && !exc_entry && !exc_return && !multi_suspend && !block_start |=> !block_active)
		else $error("single-instruction block did not end");

	// ==========================================
	// field shape while a transfer is suspended
	resume_upper_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		resume_valid |-> field_q[7:6] == 2'h0)
		else $error("resume state upper pair not zero");
	resume_lower_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		resume_valid |-> field_q[1:0] == 2'h0)
		else $error("resume state low pair not zero");

	// a suspended transfer stays recorded until something ends it
	sequence resume_quiet_s;
		resume_valid && !exc_entry && !exc_return && !multi_suspend && !multi_finish && !block_start;
	endsequence
	resume_keep_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		resume_quiet_s |=> resume_valid && $stable(resume_reg))
		else $error("resume register lost");
	finish_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		multi_finish && resume_valid && !exc_entry && !exc_return && !multi_suspend |=> !resume_valid)
		else $error("resume state not cleared on finish");

	// ==========================================
	// conditional block tracking
	block_load_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		block_start && block_mask != 4'h0 && !exc_entry && !exc_return && !multi_suspend && !multi_finish
		|=> block_active && block_cond_out == $past(block_cond))
		else $error("block prefix not loaded");
	// one retired instruction inside a block with no higher event
	sequence block_step_s;
		block_active && exec_done && !exc_entry && !exc_return && !multi_suspend && !multi_finish && !block_start;
	endsequence
	// a cycle inside a block where nothing retires and nothing overrides
	sequence block_idle_s;
		block_active && !exec_done && !exc_entry && !exc_return && !multi_suspend && !multi_finish && !block_start;
	endsequence
	block_cond_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		block_step_s |=> !block_active || block_cond_out[3:1] == $past(block_cond_out[3:1]))
		else $error("block condition not same or inverse");
	block_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		block_idle_s |=> block_active && $stable(block_cond_out))
		else $error("block state moved without retire");

	// ==========================================
	// software view of the bits
	write_ignored_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		status_write && !exc_entry && !exc_return && !multi_suspend && !multi_finish && !block_start && !exec_done
		|=> $stable(field_q))
		else $error("status write changed field");
	rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		!status_read |=> status_rdata == 32'h0000_0000)
		else $error("read data without a read");
	view_app_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		status_read && (status_view == exec_state_pkg::VIEW_APP_INT || status_view == exec_state_pkg::VIEW_APP)
		|=> status_rdata == 32'h0000_0000)
		else $error("other view returned bits");
	full_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		status_read && privileged && status_view == exec_state_pkg::VIEW_FULL
		|=> status_rdata[exec_state_pkg::ISET_POS] == $past(iset_q))
		else $error("set-state bit not returned");
	other_bits_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		status_rdata[31:27] == 5'h00 && status_rdata[5:0] == 6'h00)
		else $error("bits outside the view returned");

	// ==========================================
	// stacking and restore
	stack_rsvd_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		stack_status[23:16] == 8'h00 && stack_status[9:6] == 4'h0)
		else $error("stacked reserved bits not zero");
	return_restore_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		exc_return && !exc_entry |=> field_q == $past({stacked_status[26:25], stacked_status[15:10]}))
		else $error("return did not restore field");

	// ==========================================
	// set-state bit sources and fault
	branch_copy_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		branch_exch && !vector_load && !exc_return |=> iset_q == $past(branch_target[0]))
		else $error("branch did not set state bit");
	return_iset_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		exc_return && !vector_load |=> iset_q == $past(stacked_status[exec_state_pkg::ISET_POS]))
		else $error("return did not restore state bit");
	fault_none_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		iset_q || !exec_valid |=> !iset_fault)
		else $error("fault without cause");
	boot_quiet_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		boot_q |=> !iset_fault)
		else $error("fault before vector fetch");
endmodule

//--- tb.sv
`timescale 1ns/100ps
module tb;
	logic sys_clk, rstn, exec_valid, exec_done, block_start, multi_suspend, multi_finish, exc_entry, exc_return;
	logic vector_load, branch_exch, status_read, status_write, privileged;
	logic [3:0] block_cond, block_mask, multi_next_reg, resume_reg, block_cond_out;
	logic [1:0] status_view;
	logic [31:0] stacked_status, vector_word, branch_target, status_wdata, status_rdata, stack_status;
	logic resume_valid, block_active, iset_fault;
	int error_cnt = 0;
	int checks_done = 0;
	// ==========================================
	// ordinary cases: event kind, small arg, word arg, expected full-view read
	typedef struct {int k; logic [3:0] a; logic [31:0] b; logic [31:0] e;} row_t;
	row_t rows[9] = '{'{4, 4'h0, 32'h0000_0101, 32'h0100_0000}, '{0, 4'h5, 32'h0, 32'h0100_5000},
		'{1, 4'h0, 32'h0, 32'h0100_0000}, '{2, 4'h6, 32'h8, 32'h0500_6000}, '{3, 4'h0, 32'h0, 32'h0100_0000},
		'{5, 4'h0, 32'h0, 32'h0000_0000}, '{5, 4'h0, 32'h1, 32'h0100_0000},
		'{6, 4'h0, 32'hf9ff_33ff, 32'h0100_3000}, '{1, 4'h0, 32'h0, 32'h0100_0000}};
	exec_state_bits uut (.sys_clk(sys_clk), .rstn(rstn), .exec_valid(exec_valid), .exec_done(exec_done),
		.block_start(block_start), .block_cond(block_cond), .block_mask(block_mask), .multi_suspend(multi_suspend),
		.multi_next_reg(multi_next_reg), .multi_finish(multi_finish), .exc_entry(exc_entry), .exc_return(exc_return),
		.stacked_status(stacked_status), .vector_load(vector_load), .vector_word(vector_word),
		.branch_exch(branch_exch), .branch_target(branch_target), .status_read(status_read),
		.status_write(status_write), .privileged(privileged), .status_view(status_view),
		.status_wdata(status_wdata), .status_rdata(status_rdata), .stack_status(stack_status),
		.resume_valid(resume_valid), .resume_reg(resume_reg), .block_cond_out(block_cond_out),
		.block_active(block_active), .iset_fault(iset_fault));
	// ==========================================
	// clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// one-cycle event pulse, result settled on return
	task automatic op(input int k, input logic [3:0] a, input logic [31:0] b);
		@(posedge sys_clk);
		case (k)
			0: begin multi_suspend <= 1'b1; multi_next_reg <= a; end
			1: multi_finish <= 1'b1;
			2: begin block_start <= 1'b1; block_cond <= a; block_mask <= b[3:0]; end
			3: exec_done <= 1'b1;
			4: begin vector_load <= 1'b1; vector_word <= b; end
			5: begin branch_exch <= 1'b1; branch_target <= b; end
			6: begin exc_return <= 1'b1; stacked_status <= b; end
			7: exc_entry <= 1'b1;
			8: exec_valid <= 1'b1;
			default: begin status_write <= 1'b1; status_wdata <= b; status_view <= a[1:0]; end
		endcase
		@(posedge sys_clk);
		{multi_suspend, multi_finish, block_start, exec_done, vector_load, branch_exch} <= 6'h00;
		{exc_return, exc_entry, exec_valid, status_write} <= 4'h0;
		#1;
	endtask
	// status-move read through one view
	task automatic rd(input logic [1:0] v, input logic p);
		@(posedge sys_clk);
		status_read <= 1'b1;
		status_view <= v;
		privileged <= p;
		@(posedge sys_clk);
		status_read <= 1'b0;
		privileged <= 1'b1;
		#1;
	endtask
	task automatic stop_test;
		if (error_cnt == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// ==========================================
	// main sequence
	initial begin
		{exec_valid, exec_done, block_start, multi_suspend, multi_finish, exc_entry, exc_return} = 7'h00;
		{vector_load, branch_exch, status_read, status_write} = 4'h0;
		{block_cond, block_mask, multi_next_reg} = 12'h000;
		{stacked_status, vector_word, branch_target, status_wdata} = 128'h0;
		privileged = 1'b1;
		status_view = 2'h0;
		rstn = 1'b0;
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		rd(2'h0, 1'b1); chk(status_rdata, 32'h0100_0000);
		foreach (rows[i]) begin
			op(rows[i].k, rows[i].a, rows[i].b);
			rd(2'h0, 1'b1); chk(status_rdata, rows[i].e);
		end
		op(0, 4'hf, 32'h0);
		chk({resume_valid, resume_reg}, 32'h1f);
		op(7, 4'h0, 32'h0);
		chk(stack_status, 32'h0100_f000);
		rd(2'h0, 1'b0); chk(status_rdata, 32'h0);
		rd(2'h2, 1'b1); chk(status_rdata, 32'h0);
		rd(2'h3, 1'b1); chk(status_rdata, 32'h0);
		op(9, 4'h0, 32'hffff_ffff);
		rd(2'h1, 1'b1); chk(status_rdata, 32'h0100_0000);
		op(1, 4'h0, 32'h0);
		@(posedge sys_clk);
		block_start <= 1'b1; block_cond <= 4'h6; block_mask <= 4'hc;
		@(posedge sys_clk);
		block_start <= 1'b0;
		#1 chk({block_active, block_cond_out}, 32'h16);
		@(posedge sys_clk);
		exec_done <= 1'b1;
		@(posedge sys_clk);
		exec_done <= 1'b0;
		#1 chk({block_active, block_cond_out}, 32'h17);
		@(posedge sys_clk);
		exec_done <= 1'b1;
		@(posedge sys_clk);
		exec_done <= 1'b0;
		#1 chk({block_active, block_cond_out}, 32'h00);
		@(posedge sys_clk);
		block_start <= 1'b1; block_cond <= 4'h0; block_mask <= 4'h8;
		@(posedge sys_clk);
		block_start <= 1'b0;
		exec_done <= 1'b1;
		@(posedge sys_clk);
		exec_done <= 1'b0;
		#1 chk(block_active, 32'h0);
		op(8, 4'h0, 32'h0); chk(iset_fault, 32'h0);
		op(4, 4'h0, 32'h0000_0100);
		op(8, 4'h0, 32'h0); chk(iset_fault, 32'h1);
		@(posedge sys_clk);
		rstn <= 1'b0;
		@(posedge sys_clk);
		rstn <= 1'b1;
		rd(2'h0, 1'b1); chk(status_rdata, 32'h0100_0000);
		stop_test();
	end
endmodule
